// >>> logic/scr_pkg.sv
// constants and types of the synthesizer control register file
package scr_pkg;
   localparam int unsigned WORD_W       = 22;
   localparam int unsigned DATA_W       = 20;
   localparam int unsigned ADDR_LSB     = 0;
   localparam int unsigned ADDR_MSB     = 1;
   localparam logic [1:0]  ADDR_IF_REF  = 2'h0;
   localparam logic [1:0]  ADDR_IF_FB   = 2'h1;
   localparam logic [1:0]  ADDR_RF_REF  = 2'h2;
   localparam logic [1:0]  ADDR_RF_FB   = 2'h3;
   // reference register fields, positions in the 22-bit word
   localparam int unsigned REF_DIV_LSB  = 2;
   localparam int unsigned REF_DIV_MSB  = 16;
   localparam int unsigned POL_BIT      = 17;
   localparam int unsigned CUR_BIT      = 18;
   localparam int unsigned HIZ_BIT      = 19;
   localparam int unsigned MOS_LO_BIT   = 20;
   localparam int unsigned MOS_HI_BIT   = 21;
   // feedback register fields
   localparam int unsigned SWA_LSB      = 2;
   localparam int unsigned SWA_USED_MSB = 5;
   localparam int unsigned BIN_LSB      = 9;
   localparam int unsigned BIN_MSB      = 19;
   localparam int unsigned PRE_BIT      = 20;
   localparam int unsigned PWD_BIT      = 21;
   // no documented reset value; zero chosen
   localparam logic [DATA_W-1:0] REG_RST = 20'h00000;
   localparam logic [WORD_W-1:0] SHIFT_RST = 22'h000000;
   // loop operating modes {pump_high_z, power_down}
   typedef enum logic [3:0] {
      SCR_NORMAL  = 4'h1,
      SCR_HIZ     = 4'h2,
      SCR_SYNC_PD = 4'h4,
      SCR_ASYN_PD = 4'h8
   } scr_mode_t;
endpackage

// >>> logic/scr_sync.sv
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module scr_sync (
   input  wire logic refClk,   // sampling clock
   input  wire logic nrst,     // async reset, active low
   input  wire logic asyncIn,  // outside level
   output logic      syncOut   // synchronised level
);
   logic meta_ff;

   always_ff @(posedge refClk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         meta_ff <= asyncIn;
         syncOut <= meta_ff;
      end
   end
endmodule

// >>> logic/scr_control_regs.sv
// serial-loaded write-only control register file with IF loop decode
`timescale 1ns/1ps
import scr_pkg::*;

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1 - low two word bits pick target register
// R2 - IF reference fields at bits 2..21
// R3 - host keeps reference divide 3 to 32767
// R4 - polarity bit picks negative or positive tuning
// R5 - current bit picks 0.95 or 3.80 mA
// R6 - high-z bit floats pump immediately
// R7 - IF feedback fields at bits 2..21
// R8 - swallow count upper three bits ignored
// R9 - host keeps binary count 3 to 2047
// R10 - prescaler bit picks 8/9 or 16/17
// R11 - powerdown bit parks the IF loop
// R12 - high-z plus powerdown pick pd style
// R13 - mode table normal, hiz, sync, async
// R14 - sync waits pump pulse end, async immediate
// R15 - MSB first shift, load on strobe rise
// R16 - only addressed register updates, all fields
module scr_control_regs
   import scr_pkg::*;
(
   input  wire logic        ref_clk,          // 125 MHz system clock
   input  wire logic        nrst,             // async reset, active low
   input  wire logic        serClk,           // serial clock pin
   input  wire logic        serData,          // serial data pin
   input  wire logic        latchStrobe,      // latch strobe pin
   input  wire logic        ifPumpPulse,      // IF pump active, same domain
   output logic [14:0]      refDivideValue_ff,  // IF reference divide
   output logic             detectorPolarity_ff, // 1 positive tuning
   output logic             pumpCurrentSel_ff,  // 1 high 3.80 mA
   output logic             pumpHighZ_ff,       // IF pump output floated
   output logic [1:0]       multiOutSel_ff,     // output select bits 21:20
   output logic [3:0]       swallowCount_ff,    // IF swallow count 0..15
   output logic [10:0]      binaryCount_ff,     // IF binary count
   output logic             prescalerSel_ff,    // 1 selects 16/17
   output logic             ifPowerDown_ff,     // IF loop powered down
   output logic [3:0]       ifMode_ff,          // one-hot operating mode
   output logic [DATA_W-1:0] rfReference_ff,    // RF reference data
   output logic [DATA_W-1:0] rfFeedback_ff      // RF feedback data
);
   //////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   // every pin is outside the clock domain, so each one passes two
   // flops before any logic reads it; this costs two cycles of
   // latency but keeps metastability out of the shift register
   logic sClk;
   logic sData;
   logic sLatch;

   scr_sync uSyncClk (
      .refClk  (ref_clk),
      .nrst    (nrst),
      .asyncIn (serClk),
      .syncOut (sClk)
   );
   scr_sync uSyncData (
      .refClk  (ref_clk),
      .nrst    (nrst),
      .asyncIn (serData),
      .syncOut (sData)
   );
   scr_sync uSyncLatch (
      .refClk  (ref_clk),
      .nrst    (nrst),
      .asyncIn (latchStrobe),
      .syncOut (sLatch)
   );

   //////////////////////////////////////////////////////////////////////////
   // edge detection and shift register
   // pin pulses shorter than one clock period may be missed; the host
   // must keep the serial clock high and low for at least three cycles
   // delayed copies reset low, matching the idle pin level, so that
   // no false edge follows reset
   logic              sClkDly_ff;
   logic              sLatchDly_ff;
   logic [WORD_W-1:0] shift_ff;
   wire               clkRise   = sClk & ~sClkDly_ff;
   wire               latchRise = sLatch & ~sLatchDly_ff;
   wire [WORD_W-1:0]  nxt_shift = {shift_ff[WORD_W-2:0], sData}; // [R15]
   wire [1:0]         addrSel   = shift_ff[ADDR_MSB:ADDR_LSB];  // [R1]
   wire [DATA_W-1:0]  dataField = shift_ff[WORD_W-1:ADDR_MSB+1];
   wire               ldIfRef   = latchRise & (addrSel == ADDR_IF_REF); // [R1]
   wire               ldIfFb    = latchRise & (addrSel == ADDR_IF_FB);
   wire               ldRfRef   = latchRise & (addrSel == ADDR_RF_REF);
   wire               ldRfFb    = latchRise & (addrSel == ADDR_RF_FB);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sClkDly_ff   <= 1'b0;
         sLatchDly_ff <= 1'b0;
         shift_ff     <= SHIFT_RST;
      end else begin
         sClkDly_ff   <= sClk;
         sLatchDly_ff <= sLatch;
         // extra bits fall off the top; only the last 22 matter
         if (clkRise) begin
            shift_ff <= nxt_shift; // [R15]
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // control registers; loading works in powerdown too
   // one load strobe per register, so the other three hold their value
   // and all fields of the addressed one change on the same edge
   logic [DATA_W-1:0] ifReference_ff;
   logic [DATA_W-1:0] ifFeedback_ff;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ifReference_ff <= REG_RST;
         ifFeedback_ff  <= REG_RST;
         rfReference_ff <= REG_RST;
         rfFeedback_ff  <= REG_RST;
      end else begin
         if (ldIfRef) begin
            ifReference_ff <= dataField; // [R16] [R15]
         end
         if (ldIfFb) begin
            ifFeedback_ff <= dataField; // [R16]
         end
         if (ldRfRef) begin
            rfReference_ff <= dataField; // [R16]
         end
         if (ldRfFb) begin
            rfFeedback_ff <= dataField; // [R16]
         end
      end
   end

   // full 22-bit word view, so package positions apply directly
   wire [WORD_W-1:0] ifRefWord = {ifReference_ff, ADDR_IF_REF};
   wire [WORD_W-1:0] ifFbWord  = {ifFeedback_ff, ADDR_IF_FB};

   //////////////////////////////////////////////////////////////////////////
   // field outputs
   // selection as named wires; the flops below only register them
   wire [14:0] refDivSel = ifRefWord[REF_DIV_MSB:REF_DIV_LSB]; // [R2]
   wire        polSel    = ifRefWord[POL_BIT];                 // [R4]
   wire        curSel    = ifRefWord[CUR_BIT];                 // [R5]
   wire        hizSel    = ifRefWord[HIZ_BIT];                 // [R6]
   wire [1:0]  mosSel    = ifRefWord[MOS_HI_BIT:MOS_LO_BIT];   // [R2]
   // bits 8:6 of the swallow field are dropped here on purpose
   wire [3:0]  swaSel    = ifFbWord[SWA_USED_MSB:SWA_LSB];     // [R8]
   wire [10:0] binSel    = ifFbWord[BIN_MSB:BIN_LSB];          // [R7]
   wire        preSel    = ifFbWord[PRE_BIT];                  // [R10]

   // reference fields; high-z follows the bit with no pump alignment
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         refDivideValue_ff   <= 15'h0000;
         detectorPolarity_ff <= 1'b0;
         pumpCurrentSel_ff   <= 1'b0;
         pumpHighZ_ff        <= 1'b0;
         multiOutSel_ff      <= 2'h0;
      end else begin
         refDivideValue_ff   <= refDivSel; // [R2] [R3]
         detectorPolarity_ff <= polSel; // [R4]
         pumpCurrentSel_ff   <= curSel; // [R5]
         pumpHighZ_ff        <= hizSel; // [R6]
         multiOutSel_ff      <= mosSel; // [R2]
      end
   end

   // feedback fields; range limits are the host's to keep
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         swallowCount_ff <= 4'h0;
         binaryCount_ff  <= 11'h000;
         prescalerSel_ff <= 1'b0;
      end else begin
         swallowCount_ff <= swaSel; // [R7] [R8]
         binaryCount_ff  <= binSel; // [R7] [R9]
         prescalerSel_ff <= preSel; // [R10]
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // operating mode and powerdown timing
   logic      pumpPulseDly_ff;
   scr_mode_t nxt_mode;
   wire       hizBit    = ifRefWord[HIZ_BIT];
   wire       pdBit     = ifFbWord[PWD_BIT];
   wire       pulseDone = pumpPulseDly_ff & ~ifPumpPulse;

   // the two bits live in different registers but decode as one word
   always_comb begin
      case ({hizBit, pdBit}) // [R12] [R13]
         2'b00:   nxt_mode = SCR_NORMAL;
         2'b10:   nxt_mode = SCR_HIZ;
         2'b01:   nxt_mode = SCR_SYNC_PD;
         2'b11:   nxt_mode = SCR_ASYN_PD;
         default: nxt_mode = SCR_NORMAL;
      endcase
   end

   // async request goes down at once; sync waits for a pulse to end
   // and, once down, stays down while the bit is set
   wire asyncDown = pdBit & (nxt_mode == SCR_ASYN_PD); // [R14]
   wire syncDown  = pdBit & (ifPowerDown_ff | pulseDone); // [R14]
   // clearing the bit powers the loop up again on the next edge
   wire nxt_pd    = asyncDown | syncDown; // [R11]

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pumpPulseDly_ff <= 1'b0;
         ifPowerDown_ff  <= 1'b0;
         ifMode_ff       <= SCR_NORMAL;
      end else begin
         pumpPulseDly_ff <= ifPumpPulse;
         ifPowerDown_ff  <= nxt_pd; // [R11] [R14]
         ifMode_ff       <= nxt_mode; // [R13]
      end
   end
endmodule

// >>> dv/scr_sva.sv
// assertions on the control register file ports
`timescale 1ns/1ps
module scr_sva (
   input wire logic        ref_clk,             // clock
   input wire logic        nrst,                // reset
   input wire logic        latchStrobe,         // load pin
   input wire logic        ifPumpPulse,         // pump active
   input wire logic [14:0] refDivideValue_ff,   // divide
   input wire logic        detectorPolarity_ff, // polarity
   input wire logic        pumpCurrentSel_ff,   // current
   input wire logic        pumpHighZ_ff,        // pump floated
   input wire logic [1:0]  multiOutSel_ff,      // output select
   input wire logic [3:0]  swallowCount_ff,     // swallow
   input wire logic [10:0] binaryCount_ff,      // binary
   input wire logic        prescalerSel_ff,     // prescaler
   input wire logic        ifPowerDown_ff,      // loop down
   input wire logic [3:0]  ifMode_ff,           // mode
   input wire logic [19:0] rfReference_ff,      // rf ref
   input wire logic [19:0] rfFeedback_ff        // rf fb
);
////////////////////////////////////////
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   wire logic [19:0] ifRef = {multiOutSel_ff, pumpHighZ_ff,
      pumpCurrentSel_ff, detectorPolarity_ff, refDivideValue_ff};
   wire logic [15:0] ifFb = {prescalerSel_ff, binaryCount_ff,
      swallowCount_ff};
   mode_onehot_a: assert property ($onehot(ifMode_ff))
      else $error("mode not one-hot");
   hiz_mode_a: assert property (
      (ifMode_ff[1] | ifMode_ff[3]) == pumpHighZ_ff) else $error("hiz mode");
   async_pd_a: assert property (
      $rose(ifMode_ff[3]) |=> ifPowerDown_ff) else $error("async late");
   normal_up_a: assert property (
      |ifMode_ff[1:0] |-> !ifPowerDown_ff) else $error("loop down");
   sync_wait_a: assert property (
      ifMode_ff[2] && !ifPowerDown_ff && ifPumpPulse |=> !ifPowerDown_ff)
      else $error("sync early");
   sync_enter_a: assert property (
      ifMode_ff[2] && $fell(ifPumpPulse) |-> ##[1:2] ifPowerDown_ff)
      else $error("sync late");
   load_time_a: assert property (
      $changed({ifRef, ifFb, rfReference_ff, rfFeedback_ff})
      |-> $past(latchStrobe, 2)) else $error("load without strobe");
   one_target_a: assert property ($changed(ifRef) |-> $stable(ifFb)
      && $stable({rfReference_ff, rfFeedback_ff})) else $error("two loads");
   cover property (ifMode_ff[2] ##1 ifPowerDown_ff);
   cover property ($rose(ifMode_ff[3]));
   cover property ($rose(ifMode_ff[1]));
endmodule

// >>> dv/scr_host_model.sv
// host that shifts one word on the three-wire port per go pulse
`timescale 1ns/1ps
module scr_host_model (
   input  wire logic        ref_clk,     // bench clock
   input  wire logic        go,          // rise starts a word
   input  wire logic [21:0] word,        // word to send
   output logic             serClk,      // serial clock
   output logic             serData,     // serial data
   output logic             latchStrobe, // load strobe
   output logic             busy         // word in flight
);
   initial {serClk, serData, latchStrobe, busy} = 4'h0;
   // 64 ns serial clock; stands low between words
   always @(posedge go) begin
      busy <= 1'b1;
      for (int i = 21; i >= 0; i--) begin
         serData <= word[i];
         repeat (4) @(posedge ref_clk);
         serClk <= 1'b1;
         repeat (4) @(posedge ref_clk);
         serClk <= 1'b0;
      end
      serData <= ~word[0];
      repeat (4) @(posedge ref_clk);
      latchStrobe <= 1'b1;
      repeat (4) @(posedge ref_clk);
      latchStrobe <= 1'b0;
      busy <= 1'b0;
   end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the control register file
`timescale 1ns/1ps
module testbench;
   import scr_pkg::*;
   typedef struct packed {logic [21:0] w; logic [3:0] m; logic p;} scr_row_t;
   logic ref_clk = 1'b0, nrst = 1'b0, ifPumpPulse = 1'b0, go = 1'b0;
   logic [21:0] word = 22'h000000, lr = '0, lf = '0, lrr = '0, lrf = '0;
   logic serClk, serData, latchStrobe, busy, detectorPolarity_ff;
   logic pumpCurrentSel_ff, pumpHighZ_ff, prescalerSel_ff, ifPowerDown_ff;
   logic [1:0] multiOutSel_ff;
   logic [3:0] swallowCount_ff, ifMode_ff;
   logic [10:0] binaryCount_ff;
   logic [14:0] refDivideValue_ff;
   logic [DATA_W-1:0] rfReference_ff, rfFeedback_ff;
   int errors = 0, checks_done = 0;
   scr_row_t rows [8] = '{
      '{22'h22000c, 4'h1, 1'b0}, // divide 3
      '{22'h1fffd5, 4'h1, 1'b0}, // binary 2047, swallow 7'h75
      '{22'h2aaaaa, 4'h1, 1'b0},
      '{22'h155557, 4'h1, 1'b0},
      '{22'h1dfffc, 4'h2, 1'b0}, // divide 32767
      '{22'h200601, 4'h8, 1'b1},
      '{22'h000601, 4'h2, 1'b0},
      '{22'h00000c, 4'h1, 1'b0}};
   scr_control_regs dut (.*);
   scr_host_model host (.*);
   always #4 ref_clk = ~ref_clk;
////////////////////////////////////////
   task automatic check(string what, logic [21:0] seen, logic [21:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      if (errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic send(logic [21:0] w);
      word <= w;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 400 && busy; i++) @(posedge ref_clk);
      check("hostDone", {21'h0, busy}, 22'h0);
      repeat (4) @(posedge ref_clk);
      case (w[1:0])
         ADDR_IF_REF: lr = w;
         ADDR_IF_FB:  lf = w;
         ADDR_RF_REF: lrr = w;
         default:     lrf = w;
      endcase
   endtask
   task automatic verify(logic [3:0] m, logic p);
      check("ifRef", {2'h0, multiOutSel_ff, pumpHighZ_ff,
         pumpCurrentSel_ff, detectorPolarity_ff, refDivideValue_ff},
         {2'h0, lr[21:2]});
      check("ifFb", {6'h0, prescalerSel_ff, binaryCount_ff, swallowCount_ff},
         {6'h0, lf[20:9], lf[5:2]});
      check("rfRef", {2'h0, rfReference_ff}, {2'h0, lrr[21:2]});
      check("rfFb", {2'h0, rfFeedback_ff}, {2'h0, lrf[21:2]});
      check("mode", {18'h0, ifMode_ff}, {18'h0, m});
      check("down", {21'h0, ifPowerDown_ff}, {21'h0, p});
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         send(rows[i].w);
         verify(rows[i].m, rows[i].p);
      end
      // sync powerdown must wait for the pump pulse to end
      ifPumpPulse <= 1'b1;
      send(22'h200601);
      verify(4'h4, 1'b0);
      ifPumpPulse <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check("syncDown", {21'h0, ifPowerDown_ff}, 22'h1);
      nrst <= 1'b0;
      @(posedge ref_clk);
      {lr, lf, lrr, lrf} = '0;
      verify(4'h1, 1'b0);
      print_verdict();
   end
   // nine words of about 200 cycles each; about fourteen times that is a hang
   initial begin
      #200000;
      errors++;
      print_verdict();
   end
endmodule
bind scr_control_regs scr_sva chk (.*);
